// file: logic/gpwk_pkg.sv
// Purpose: constants for the port pin, wake and interrupt block
// Assumes: register index space of 8 bits, byte-wide registers
// Notes: indices name one byte register each
package gpwk_pkg;
    // control register fields
    localparam int CTL_DIR = 0;
    localparam int CTL_POL = 1;
    localparam int CTL_OD = 7;
    localparam logic [7:0] CTL_RESET = 8'h01;
    localparam logic [7:0] CTL_RESET_OUTLOW = 8'h00;
    // register map
    localparam logic [7:0] ADDR_CTL_BASE = 8'h00;
    localparam logic [7:0] ADDR_DATA_BASE = 8'h40;
    localparam logic [7:0] ADDR_WAKE_EN = 8'h60;
    localparam logic [7:0] ADDR_WSTS2 = 8'h61;
    localparam logic [7:0] ADDR_WSTS3 = 8'h62;
    localparam logic [7:0] ADDR_WSTS4 = 8'h63;
    localparam logic [7:0] ADDR_WSTS5 = 8'h64;
    localparam logic [7:0] ADDR_WEN2 = 8'h65;
    localparam logic [7:0] ADDR_WEN3 = 8'h66;
    localparam logic [7:0] ADDR_WEN4 = 8'h67;
    localparam logic [7:0] ADDR_WEN5 = 8'h68;
    localparam logic [7:0] ADDR_ISTS3 = 8'h69;
    localparam logic [7:0] ADDR_ISTS4 = 8'h6a;
    localparam logic [7:0] ADDR_ISTS5 = 8'h6b;
    localparam logic [7:0] ADDR_IEN3 = 8'h6c;
    localparam logic [7:0] ADDR_IEN4 = 8'h6d;
    localparam logic [7:0] ADDR_IEN5 = 8'h6e;
    localparam logic [7:0] ADDR_MISC = 8'h6f;
    localparam logic [7:0] ADDR_ALT = 8'h70;
    // pin indices: port p bit b is (p-1)*8+b, ports 1..6 -> 0..47
    localparam int NPIN = 48;
    // alternate function select bits
    localparam int ALT_JOY = 0;
    localparam int ALT_KBD = 1;
    localparam int ALT_EDGE = 2;
    localparam int ALT_DDEN = 3;
    localparam int ALT_MGMT = 4;
    localparam logic [7:0] ALT_RESET = 8'h00;
endpackage

// file: logic/gpwk_port.sv
// Operation
// R01: each pin owns eight-bit control register
// R02: direction 0 output, polarity 1 inverts
// R03: bit seven picks open-drain or push-pull
// R04: polarity inverts alternates except three exempt
// R05: joystick pins become open-drain non-inverted outputs
// R06: keyboard and joystick functions are bidirectional
// R07: input read returns pin, polarity applied
// R08: data write to input pin ignored
// R09: output pin drives stored bit, polarity applied
// R10: output read returns last written bit
// R11: output pins never raise wake or interrupt; fan pins 3.0 and 3.1 still set interrupt status in any direction
// R12: polarity selects wake edge, rising default
// R13: wake out needs status, pin and global enable
// R14: status bits clear on host write one
// R15: wake status grouped into four registers
// R16: interrupt status grouped into three registers
// R17: either-edge pins set misc, wake, irq status
// R18: pins 3.2 3.3 5.3 reset to output low
// R19: pin 4.3 resets to plain port function
// R20: host keeps pin 2.7 irq off when output
// R21: registers at fixed offsets in wake block
// R22: either-edge ignores direction, polarity, driver type
// R23: two-flop sync, set beats write-one clear
//
// Purpose: port pin control, data, wake and interrupt status
// Assumes: host strobes one cycle, read data next cycle
// Notes: pin index is port*8+bit minus eight
//
// Decided for this implementation: strobed register access and the address map.
`timescale 1ns/100ps
module gpwk_port #(
    parameter int NPIN = gpwk_pkg::NPIN
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // pins
    input wire logic [NPIN-1:0] pin_in,
    output logic [NPIN-1:0] pin_out,
    output logic [NPIN-1:0] pin_oe_n,
    // alternate function values
    input wire logic [NPIN-1:0] alt_out,
    output logic [NPIN-1:0] alt_in,
    // events
    output logic wake_event,
    output logic mgmt_irq
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic int pidx(input int port, input int bitn);
        return (port - 1) * 8 + bitn;
    endfunction

    function automatic int didx(input logic [7:0] addr, input int bitn);
        return (int'(addr) - int'(gpwk_pkg::ADDR_DATA_BASE)) * 8 + bitn;
    endfunction

    function automatic logic [7:0] clr_set(input logic [7:0] cur,
        input logic [7:0] set, input logic [7:0] clr);
        return (cur & ~clr) | set;
    endfunction

    logic [7:0] ctl_r [NPIN];
    logic [NPIN-1:0] data_r;
    logic [NPIN-1:0] sync1_r, sync2_r, prev_r;
    logic [7:0] alt_r;
    logic global_wake_enable_r;
    logic [7:0] wsts_r [2:5];
    logic [7:0] wen_r [2:5];
    logic [7:0] ists_r [3:5];
    logic [7:0] ien_r [3:5];
    logic [7:0] misc_edge_status_r;
    logic [7:0] reg_rdata_r;
    logic [NPIN-1:0] is_in, pol, edge_sel, fire, exempt;
    logic [NPIN-1:0] rise, fall;
    logic [7:0] wset [2:5];
    logic [7:0] iset [3:5];
    logic [7:0] mset;
    logic [7:0] rd_nxt;
    logic [7:0] wclr;
    logic fan1_ev, fan2_ev;

    // ------------------------------------------------------------
    // pin sync and edges
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            // pulled-up idle level, so release gives no false rise
            sync1_r <= '1;
            sync2_r <= '1;
            prev_r <= '1;
        end
        else
        begin
            sync1_r <= pin_in; // [R23]
            sync2_r <= sync1_r; // [R23]
            prev_r <= sync2_r;
        end
    end

    assign rise = sync2_r & ~prev_r;
    assign fall = ~sync2_r & prev_r;

    // either-edge capable pins
    always_comb
    begin
        edge_sel = '0;
        if (alt_r[gpwk_pkg::ALT_EDGE])
        begin
            edge_sel[pidx(2,1)] = 1'b1;
            edge_sel[pidx(2,2)] = 1'b1;
            edge_sel[pidx(4,1)] = 1'b1;
            edge_sel[pidx(4,3)] = 1'b1;
            edge_sel[pidx(6,0)] = 1'b1;
            edge_sel[pidx(6,1)] = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // pin drive
    // ------------------------------------------------------------
    always_comb
    begin
        exempt = edge_sel;
        if (alt_r[gpwk_pkg::ALT_DDEN])
            exempt[pidx(4,3)] = 1'b1; // [R04]
        for (int i = 0; i < NPIN; i++)
        begin
            is_in[i] = ctl_r[i][gpwk_pkg::CTL_DIR] | edge_sel[i]; // [R22]
            pol[i] = ctl_r[i][gpwk_pkg::CTL_POL];
        end
    end

    always_comb
    begin
        logic v;
        v = 1'b0;
        for (int i = 0; i < NPIN; i++)
        begin
            if (alt_r[gpwk_pkg::ALT_MGMT] && i == pidx(2,7))
                v = alt_out[i] ^ pol[i]; // [R03] [R04]
            else
                v = data_r[i] ^ pol[i]; // [R02] [R09]
            pin_out[i] = v;
            if (is_in[i])
                pin_oe_n[i] = 1'b1;
            else if (ctl_r[i][gpwk_pkg::CTL_OD])
                pin_oe_n[i] = v; // [R03]
            else
                pin_oe_n[i] = 1'b0;
            alt_in[i] = exempt[i] ? sync2_r[i] : sync2_r[i] ^ pol[i];
        end
        if (alt_r[gpwk_pkg::ALT_JOY])
            for (int b = 4; b < 8; b++)
            begin
                pin_out[pidx(1,b)] = alt_out[pidx(1,b)]; // [R05]
                pin_oe_n[pidx(1,b)] = alt_out[pidx(1,b)]; // [R05] [R06]
                alt_in[pidx(1,b)] = sync2_r[pidx(1,b)]; // [R04]
            end
        if (alt_r[gpwk_pkg::ALT_KBD])
        begin
            // open-drain bidirectional keyboard lines
            pin_out[pidx(1,2)] = alt_out[pidx(1,2)]; // [R06]
            pin_oe_n[pidx(1,2)] = alt_out[pidx(1,2)]; // [R06]
            pin_out[pidx(1,6)] = alt_out[pidx(1,6)]; // [R06]
            pin_oe_n[pidx(1,6)] = alt_out[pidx(1,6)]; // [R06]
            pin_out[pidx(1,7)] = alt_out[pidx(1,7)]; // [R06]
            pin_oe_n[pidx(1,7)] = alt_out[pidx(1,7)]; // [R06]
        end
    end

    // ------------------------------------------------------------
    // event detection
    // ------------------------------------------------------------
    always_comb
    begin
        for (int i = 0; i < NPIN; i++)
            if (edge_sel[i])
                fire[i] = rise[i] | fall[i]; // [R17]
            else if (!is_in[i])
                fire[i] = 1'b0; // [R11]
            else
                fire[i] = pol[i] ? fall[i] : rise[i]; // [R12]
    end

    // fan events are rising edges of pins 3.1 and 3.0, taken in any direction
    assign fan1_ev = rise[pidx(3,1)];
    assign fan2_ev = rise[pidx(3,0)];

    always_comb
    begin
        for (int b = 0; b < 8; b++)
        begin
            wset[2][b] = fire[pidx(1,b)]; // [R15]
            wset[3][b] = (b == 3) ? 1'b0 : fire[pidx(2,b)]; // [R15]
            wset[4][b] = (b < 4) ? fire[pidx(3,b)] : 1'b0; // [R15]
            wset[5][b] = fire[pidx(5,b)]; // [R15]
            iset[3][b] = (b == 3) ? 1'b0 : fire[pidx(2,b)]; // [R16]
            iset[4][b] = (b < 4) ? fire[pidx(3,b)] : 1'b0; // [R16]
            iset[5][b] = (b > 3) ? fire[pidx(5,b)] : 1'b0; // [R16]
        end
        wset[4][4] = fire[pidx(4,1)];
        wset[4][5] = fire[pidx(4,3)];
        wset[4][6] = fire[pidx(6,0)];
        wset[4][7] = fire[pidx(6,1)];
        iset[3][3] = fire[pidx(6,0)]; // [R16]
        iset[3][7] = 1'b0;
        iset[4][4] = fire[pidx(4,1)];
        iset[4][5] = fire[pidx(4,2)];
        iset[4][6] = fire[pidx(4,3)];
        iset[4][7] = fire[pidx(6,1)];
        iset[5][0] = fan1_ev;
        iset[5][1] = fan2_ev;
        mset = '0;
        mset[0] = edge_sel[pidx(2,1)] & fire[pidx(2,1)]; // [R17]
        mset[1] = edge_sel[pidx(2,2)] & fire[pidx(2,2)];
        mset[2] = edge_sel[pidx(4,1)] & fire[pidx(4,1)];
        mset[3] = edge_sel[pidx(4,3)] & fire[pidx(4,3)];
        mset[4] = edge_sel[pidx(6,0)] & fire[pidx(6,0)];
        mset[5] = edge_sel[pidx(6,1)] & fire[pidx(6,1)];
    end

    assign wclr = reg_wdata;

    // ------------------------------------------------------------
    // status registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            for (int g = 2; g < 6; g++)
                wsts_r[g] <= '0;
            for (int g = 3; g < 6; g++)
                ists_r[g] <= '0;
            misc_edge_status_r <= '0;
        end
        else
        begin
            // set wins over a same-cycle write-one clear
            wsts_r[2] <= clr_set(wsts_r[2], wset[2],
                (reg_wr && reg_addr == gpwk_pkg::ADDR_WSTS2) ? wclr
                : 8'h00); // [R14] [R23]
            wsts_r[3] <= clr_set(wsts_r[3], wset[3],
                (reg_wr && reg_addr == gpwk_pkg::ADDR_WSTS3) ? wclr
                : 8'h00); // [R14]
            wsts_r[4] <= clr_set(wsts_r[4], wset[4],
                (reg_wr && reg_addr == gpwk_pkg::ADDR_WSTS4) ? wclr
                : 8'h00); // [R14]
            wsts_r[5] <= clr_set(wsts_r[5], wset[5],
                (reg_wr && reg_addr == gpwk_pkg::ADDR_WSTS5) ? wclr
                : 8'h00); // [R14]
            ists_r[3] <= clr_set(ists_r[3], iset[3],
                (reg_wr && reg_addr == gpwk_pkg::ADDR_ISTS3) ? wclr
                : 8'h00); // [R14]
            ists_r[4] <= clr_set(ists_r[4], iset[4],
                (reg_wr && reg_addr == gpwk_pkg::ADDR_ISTS4) ? wclr
                : 8'h00); // [R14]
            ists_r[5] <= clr_set(ists_r[5], iset[5],
                (reg_wr && reg_addr == gpwk_pkg::ADDR_ISTS5) ? wclr
                : 8'h00); // [R14]
            misc_edge_status_r <= clr_set(misc_edge_status_r, mset,
                (reg_wr && reg_addr == gpwk_pkg::ADDR_MISC) ? wclr
                : 8'h00); // [R17]
        end
    end

    // ------------------------------------------------------------
    // control, data and enable registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < NPIN; i++)
                ctl_r[i] <= gpwk_pkg::CTL_RESET;
            ctl_r[pidx(3,2)] <= gpwk_pkg::CTL_RESET_OUTLOW; // [R18]
            ctl_r[pidx(3,3)] <= gpwk_pkg::CTL_RESET_OUTLOW; // [R18]
            ctl_r[pidx(5,3)] <= gpwk_pkg::CTL_RESET_OUTLOW; // [R18]
        end
        else if (reg_wr && reg_addr < gpwk_pkg::ADDR_CTL_BASE + NPIN)
            ctl_r[reg_addr[5:0]] <= reg_wdata; // [R01] [R21]
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            data_r <= '0; // [R18]
        else if (reg_wr && reg_addr >= gpwk_pkg::ADDR_DATA_BASE &&
                 reg_addr < gpwk_pkg::ADDR_DATA_BASE + 8'h06)
            for (int b = 0; b < 8; b++)
                if (!is_in[didx(reg_addr, b)])
                    data_r[didx(reg_addr, b)] <= reg_wdata[b]; // [R08] [R09]
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            alt_r <= gpwk_pkg::ALT_RESET; // [R19]
            global_wake_enable_r <= 1'b0;
            for (int g = 2; g < 6; g++)
                wen_r[g] <= '0;
            for (int g = 3; g < 6; g++)
                ien_r[g] <= '0;
        end
        else if (reg_wr)
            case (reg_addr)
                gpwk_pkg::ADDR_ALT: alt_r <= reg_wdata;
                gpwk_pkg::ADDR_WAKE_EN: global_wake_enable_r <= reg_wdata[0];
                gpwk_pkg::ADDR_WEN2: wen_r[2] <= reg_wdata;
                gpwk_pkg::ADDR_WEN3: wen_r[3] <= reg_wdata;
                gpwk_pkg::ADDR_WEN4: wen_r[4] <= reg_wdata;
                gpwk_pkg::ADDR_WEN5: wen_r[5] <= reg_wdata;
                gpwk_pkg::ADDR_IEN3: ien_r[3] <= reg_wdata; // [R20]
                gpwk_pkg::ADDR_IEN4: ien_r[4] <= reg_wdata;
                gpwk_pkg::ADDR_IEN5: ien_r[5] <= reg_wdata;
                default: ;
            endcase
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    always_comb
    begin
        int k;
        k = 0;
        rd_nxt = 8'h00;
        if (reg_addr < gpwk_pkg::ADDR_CTL_BASE + NPIN)
            rd_nxt = ctl_r[reg_addr[5:0]];
        else if (reg_addr >= gpwk_pkg::ADDR_DATA_BASE &&
                 reg_addr < gpwk_pkg::ADDR_DATA_BASE + 8'h06)
            for (int b = 0; b < 8; b++)
            begin
                k = didx(reg_addr, b);
                rd_nxt[b] = is_in[k] ? sync2_r[k] ^ pol[k] // [R07] [R22]
                                     : data_r[k]; // [R10]
            end
        else
            case (reg_addr)
                gpwk_pkg::ADDR_ALT: rd_nxt = alt_r;
                gpwk_pkg::ADDR_WAKE_EN: rd_nxt = {7'h00, global_wake_enable_r};
                gpwk_pkg::ADDR_WSTS2: rd_nxt = wsts_r[2];
                gpwk_pkg::ADDR_WSTS3: rd_nxt = wsts_r[3];
                gpwk_pkg::ADDR_WSTS4: rd_nxt = wsts_r[4];
                gpwk_pkg::ADDR_WSTS5: rd_nxt = wsts_r[5];
                gpwk_pkg::ADDR_WEN2: rd_nxt = wen_r[2];
                gpwk_pkg::ADDR_WEN3: rd_nxt = wen_r[3];
                gpwk_pkg::ADDR_WEN4: rd_nxt = wen_r[4];
                gpwk_pkg::ADDR_WEN5: rd_nxt = wen_r[5];
                gpwk_pkg::ADDR_ISTS3: rd_nxt = ists_r[3];
                gpwk_pkg::ADDR_ISTS4: rd_nxt = ists_r[4];
                gpwk_pkg::ADDR_ISTS5: rd_nxt = ists_r[5];
                gpwk_pkg::ADDR_IEN3: rd_nxt = ien_r[3];
                gpwk_pkg::ADDR_IEN4: rd_nxt = ien_r[4];
                gpwk_pkg::ADDR_IEN5: rd_nxt = ien_r[5];
                gpwk_pkg::ADDR_MISC: rd_nxt = misc_edge_status_r;
                default: rd_nxt = 8'h00;
            endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            reg_rdata_r <= 8'h00;
        else if (reg_rd)
            reg_rdata_r <= rd_nxt;
        else
            reg_rdata_r <= 8'h00;
    end

    assign reg_rdata = reg_rdata_r;

    // ------------------------------------------------------------
    // event outputs
    // ------------------------------------------------------------
    assign wake_event = global_wake_enable_r &&
        |((wsts_r[2] & wen_r[2]) | (wsts_r[3] & wen_r[3]) |
          (wsts_r[4] & wen_r[4]) | (wsts_r[5] & wen_r[5])); // [R13]
    assign mgmt_irq = |((ists_r[3] & ien_r[3]) | (ists_r[4] & ien_r[4]) |
                        (ists_r[5] & ien_r[5]));
endmodule

// file: verification/gpwk_port_checker.sv
// Purpose: port-level checks for the pin, wake and irq block
// Assumes: one clock, synchronous active-low reset
// Notes: bound to every gpwk_port instance
`timescale 1ns/100ps
module gpwk_port_checker #(
    parameter int NPIN = 48
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // pins and events
    input wire logic [NPIN-1:0] pin_in,
    input wire logic [NPIN-1:0] pin_out,
    input wire logic [NPIN-1:0] pin_oe_n,
    input wire logic [NPIN-1:0] alt_out,
    input wire logic wake_event,
    input wire logic mgmt_irq
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // ----------------------------------------
    // cycles since any pin level moved
    // ----------------------------------------
    logic [NPIN-1:0] pin_q_r;
    logic [3:0] quiet_r;
    always_ff @(posedge ref_clk)
    begin
        pin_q_r <= pin_in;
    end
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            quiet_r <= 4'hf;
        else if (pin_in != pin_q_r)
            quiet_r <= 4'h0;
        else if (quiet_r != 4'hf)
            quiet_r <= quiet_r + 4'h1;
    end
    // ----------------------------------------
    // properties
    // ----------------------------------------
    property p_rdata_idle;
        !$past(reg_rd) |-> reg_rdata == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data not zero outside read answer");
    property p_unmapped;
        reg_rd && reg_addr > 8'h70 |=> reg_rdata == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read returned data");
    property p_reset_outlow;
        $rose(rst_n) |-> !pin_oe_n[18] && !pin_oe_n[19] && !pin_oe_n[35]
            && !pin_out[18] && !pin_out[19] && !pin_out[35];
    endproperty
    a_reset_outlow: assert property (p_reset_outlow)
        else $error("reset output-low pins not driving low");
    property p_reset_quiet;
        $rose(rst_n) |-> !wake_event && !mgmt_irq && pin_oe_n[0];
    endproperty
    a_reset_quiet: assert property (p_reset_quiet)
        else $error("reset state not input and quiet");
    property p_pin_stable;
        !$past(reg_wr) && $stable(alt_out)
            |-> $stable(pin_out) && $stable(pin_oe_n);
    endproperty
    a_pin_stable: assert property (p_pin_stable)
        else $error("pin drive changed without a write");
    property p_wake_fall;
        $fell(wake_event) |-> $past(reg_wr);
    endproperty
    a_wake_fall: assert property (p_wake_fall)
        else $error("wake event dropped without a write");
    property p_irq_fall;
        $fell(mgmt_irq) |-> $past(reg_wr);
    endproperty
    a_irq_fall: assert property (p_irq_fall)
        else $error("irq dropped without a write");
    property p_wake_rise;
        $rose(wake_event) && !$past(reg_wr) |-> quiet_r <= 4'h5;
    endproperty
    a_wake_rise: assert property (p_wake_rise)
        else $error("wake event rose without a pin edge");
    c_wake: cover property ($rose(wake_event));
    c_irq: cover property ($rose(mgmt_irq));
    c_unmapped: cover property (reg_rd && reg_addr > 8'h70);
endmodule

bind gpwk_port gpwk_port_checker #(.NPIN(NPIN)) u_chk (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .reg_addr(reg_addr),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .pin_in(pin_in),
    .pin_out(pin_out),
    .pin_oe_n(pin_oe_n),
    .alt_out(alt_out),
    .wake_event(wake_event),
    .mgmt_irq(mgmt_irq)
);

// file: verification/gpwk_pin_model.sv
// Purpose: board side of the port pins
// Assumes: every pin has a pull-up, outside driver optional
// Notes: a released open-drain pin floats up to one unless its outside driver is enabled
`timescale 1ns/100ps
module gpwk_pin_model #(
    parameter int NPIN = 48
) (
    // device side
    input wire logic [NPIN-1:0] pin_out,
    input wire logic [NPIN-1:0] pin_oe_n,
    // outside drivers
    input wire logic [NPIN-1:0] ext_val,
    input wire logic [NPIN-1:0] ext_en,
    // resolved level
    output logic [NPIN-1:0] pin_in
);
    // device drive wins, else outside driver, else pull-up
    always_comb
    begin
        for (int i = 0; i < NPIN; i++)
            pin_in[i] = !pin_oe_n[i] ? pin_out[i] :
                (ext_en[i] ? ext_val[i] : 1'b1);
    end
endmodule

// file: verification/gpio_port_wake_smi_control_test.sv
// Purpose: directed bench for the pin, wake and irq block
// Assumes: host port with read data one cycle after strobe
// Notes: pin edges are given five cycles to reach status
`timescale 1ns/100ps
module gpio_port_wake_smi_control_test;
    localparam int NP = gpwk_pkg::NPIN;
    logic ref_clk;
    logic rst_n;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [7:0] reg_rdata;
    logic [NP-1:0] pin_in;
    logic [NP-1:0] pin_out;
    logic [NP-1:0] pin_oe_n;
    logic [NP-1:0] alt_out;
    logic [NP-1:0] alt_in;
    logic [NP-1:0] ext_val;
    logic [NP-1:0] ext_en;
    logic wake_event;
    logic mgmt_irq;
    logic [7:0] rv;
    int err_total;
    int tests_run;

    gpwk_port #(.NPIN(NP)) DUT (
        .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe_n(pin_oe_n), .alt_out(alt_out), .alt_in(alt_in),
        .wake_event(wake_event), .mgmt_irq(mgmt_irq)
    );
    gpwk_pin_model #(.NPIN(NP)) u_pins (
        .pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_val(ext_val),
        .ext_en(ext_en), .pin_in(pin_in)
    );

    initial
    begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
    task automatic setp(input int idx, input logic v);
        @(posedge ref_clk);
        ext_val[idx] <= v;
        repeat (5) @(posedge ref_clk);
        #1;
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset;
        rd(gpwk_pkg::ADDR_CTL_BASE, rv);
        chk(rv, gpwk_pkg::CTL_RESET);
        rd(8'h12, rv);
        chk(rv, gpwk_pkg::CTL_RESET_OUTLOW);
        chk(pin_oe_n[35], 1'b0);
        rd(gpwk_pkg::ADDR_ALT, rv);
        chk(rv, gpwk_pkg::ALT_RESET);
        rd(8'h80, rv);
        chk(rv, 8'h00);
    endtask
    task automatic t_output;
        wr(gpwk_pkg::ADDR_CTL_BASE, 8'h00);
        wr(gpwk_pkg::ADDR_DATA_BASE, 8'h01);
        chk(pin_out[0], 1'b1);
        chk(pin_oe_n[0], 1'b0);
        wr(gpwk_pkg::ADDR_CTL_BASE, 8'h02);
        chk(pin_in[0], 1'b0);
        rd(gpwk_pkg::ADDR_DATA_BASE, rv);
        chk(rv[0], 1'b1);
        wr(gpwk_pkg::ADDR_CTL_BASE, 8'h80);
        chk(pin_oe_n[0], 1'b1);
        wr(gpwk_pkg::ADDR_DATA_BASE, 8'h00);
        chk(pin_oe_n[0], 1'b0);
    endtask
    task automatic t_input;
        setp(1, 1'b1);
        rd(gpwk_pkg::ADDR_DATA_BASE, rv);
        chk(rv[1], 1'b1);
        wr(8'h01, 8'h03);
        rd(gpwk_pkg::ADDR_DATA_BASE, rv);
        chk(rv[1], 1'b0);
        wr(gpwk_pkg::ADDR_DATA_BASE, 8'h02);
        wr(8'h01, 8'h00);
        chk(pin_out[1], 1'b0);
    endtask
    task automatic t_wake;
        // pin 1.1 rose in the input scenario
        wr(gpwk_pkg::ADDR_WSTS2, 8'hff);
        wr(gpwk_pkg::ADDR_WEN2, 8'h04);
        wr(gpwk_pkg::ADDR_WAKE_EN, 8'h01);
        setp(2, 1'b1);
        rd(gpwk_pkg::ADDR_WSTS2, rv);
        chk(rv, 8'h04);
        chk(wake_event, 1'b1);
        wr(gpwk_pkg::ADDR_WAKE_EN, 8'h00);
        chk(wake_event, 1'b0);
        wr(gpwk_pkg::ADDR_WAKE_EN, 8'h01);
        wr(gpwk_pkg::ADDR_WSTS2, 8'hfb);
        rd(gpwk_pkg::ADDR_WSTS2, rv);
        chk(rv, 8'h04);
        wr(8'h02, 8'h03);
        wr(gpwk_pkg::ADDR_WSTS2, 8'h04);
        chk(wake_event, 1'b0);
        setp(2, 1'b0);
        rd(gpwk_pkg::ADDR_WSTS2, rv);
        chk(rv, 8'h04);
        wr(gpwk_pkg::ADDR_WSTS2, 8'h04);
        setp(2, 1'b1);
        rd(gpwk_pkg::ADDR_WSTS2, rv);
        chk(rv, 8'h00);
    endtask
    task automatic t_outexcl;
        wr(8'h03, 8'h00);
        wr(gpwk_pkg::ADDR_WSTS2, 8'hff);
        wr(gpwk_pkg::ADDR_DATA_BASE, 8'h08);
        repeat (5) @(posedge ref_clk);
        rd(gpwk_pkg::ADDR_WSTS2, rv);
        chk(rv[3], 1'b0);
    endtask
    task automatic t_edge;
        wr(gpwk_pkg::ADDR_ALT, 8'h04);
        wr(gpwk_pkg::ADDR_IEN3, 8'h02);
        wr(gpwk_pkg::ADDR_MISC, 8'hff);
        wr(gpwk_pkg::ADDR_WSTS3, 8'hff);
        wr(gpwk_pkg::ADDR_ISTS3, 8'hff);
        setp(9, 1'b1);
        rd(gpwk_pkg::ADDR_MISC, rv);
        chk(rv, 8'h01);
        rd(gpwk_pkg::ADDR_WSTS3, rv);
        chk(rv, 8'h02);
        rd(gpwk_pkg::ADDR_ISTS3, rv);
        chk(rv, 8'h02);
        chk(mgmt_irq, 1'b1);
        wr(gpwk_pkg::ADDR_MISC, 8'h01);
        wr(gpwk_pkg::ADDR_ISTS3, 8'h02);
        chk(mgmt_irq, 1'b0);
        setp(9, 1'b0);
        rd(gpwk_pkg::ADDR_MISC, rv);
        chk(rv, 8'h01);
        chk(mgmt_irq, 1'b1);
    endtask
    task automatic t_alt;
        wr(gpwk_pkg::ADDR_ALT, 8'h01);
        chk({pin_out[4], pin_oe_n[4]}, 2'b00);
        @(posedge ref_clk);
        alt_out[4] <= 1'b1;
        wr(8'h04, 8'h03);
        chk({pin_out[4], pin_oe_n[4]}, 2'b11);
        chk({alt_in[4], alt_in[2]}, 2'b00);
        wr(gpwk_pkg::ADDR_ALT, 8'h12);
        wr(8'h0f, 8'h80);
        chk({pin_oe_n[15], pin_oe_n[6]}, 2'b00);
        wr(8'h0f, 8'h82);
        chk(pin_oe_n[15], 1'b1);
    endtask

    initial
    begin
        #1000000;
        err_total++;
        wrap_up();
    end
    initial
    begin
        err_total = 0;
        tests_run = 0;
        rst_n = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        alt_out = '0;
        ext_val = '0;
        ext_en = '1;
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_reset();
        t_output();
        t_input();
        t_wake();
        t_outexcl();
        t_edge();
        t_alt();
        wrap_up();
    end
endmodule
